// ---- hdl/gdp_pkg.sv ----
// package for the gate drive protection configuration bank
// assumes one 20 MHz clock and an active-low asynchronous reset
package gdp_pkg;
  localparam int unsigned   GDP_CLK_HZ      = 20_000_000;
  localparam logic [3:0]    GDP_ADDR_LS     = 4'h4;
  localparam logic [3:0]    GDP_ADDR_OC     = 4'h5;
  localparam logic [3:0]    GDP_ADDR_SA     = 4'h6;
  localparam logic [10:0]   GDP_RST_LS      = 11'h777;
  localparam logic [10:0]   GDP_RST_OC      = 11'h145;
  localparam logic [10:0]   GDP_RST_SA      = 11'h283;
  localparam logic [10:0]   GDP_RSVD_LS     = 11'h088;
  localparam logic [10:0]   GDP_RSVD_OC     = 11'h018;
  localparam logic [10:0]   GDP_RSVD_SA     = 11'h404;
  localparam logic [2:0]    GDP_LOCK_CODE   = 3'h6;
  localparam logic [2:0]    GDP_UNLOCK_CODE = 3'h3;
  // field positions
  localparam int unsigned   GDP_CBC_BIT     = 10;
  localparam int unsigned   GDP_TDRV_LSB    = 8;
  localparam int unsigned   GDP_SRC_LSB     = 4;
  localparam int unsigned   GDP_SNK_LSB     = 0;
  localparam int unsigned   GDP_RETRY_BIT   = 10;
  localparam int unsigned   GDP_DEAD_LSB    = 8;
  localparam int unsigned   GDP_MODE_LSB    = 6;
  localparam int unsigned   GDP_SCOPE_BIT   = 5;
  localparam int unsigned   GDP_VDS_LSB     = 0;
  localparam int unsigned   GDP_VDIV_BIT    = 9;
  localparam int unsigned   GDP_LSREF_BIT   = 8;
  localparam int unsigned   GDP_GAIN_LSB    = 6;
  localparam int unsigned   GDP_DSEN_BIT    = 5;
  localparam int unsigned   GDP_CAL_BIT     = 4;
  localparam int unsigned   GDP_ACAL_BIT    = 3;
  localparam int unsigned   GDP_SLVL_LSB    = 0;
  // times in their own units and the derived cycle counts
  localparam int unsigned   GDP_RETRY_LONG_US  = 4000;
  localparam int unsigned   GDP_RETRY_SHORT_US = 50;
  localparam int unsigned   GDP_RETRY_LONG_CYC  = GDP_RETRY_LONG_US * (GDP_CLK_HZ / 1_000_000);
  localparam int unsigned   GDP_RETRY_SHORT_CYC = GDP_RETRY_SHORT_US * (GDP_CLK_HZ / 1_000_000);
  localparam int unsigned   GDP_PEAK_BASE_NS = 500;
  localparam int unsigned   GDP_DEAD_BASE_NS = 50;
  localparam int unsigned   GDP_CLK_NS       = 1_000_000_000 / GDP_CLK_HZ;
  localparam int unsigned   GDP_PEAK_BASE_CYC = (GDP_PEAK_BASE_NS + GDP_CLK_NS - 1) / GDP_CLK_NS;
  localparam int unsigned   GDP_DEAD_BASE_CYC = (GDP_DEAD_BASE_NS + GDP_CLK_NS - 1) / GDP_CLK_NS;
  typedef enum logic [1:0] {
    GDP_OC_LATCH  = 2'h0,
    GDP_OC_RETRY  = 2'h1,
    GDP_OC_REPORT = 2'h2,
    GDP_OC_IGNORE = 2'h3
  } gdp_oc_mode_t;
  typedef enum logic [2:0] {
    GDP_ST_RUN   = 3'b001,
    GDP_ST_FAULT = 3'b010,
    GDP_ST_WAIT  = 3'b100
  } gdp_state_t;
endpackage

// ---- hdl/gdp_config.sv ----
// configuration bank for low-side drive, overcurrent handling and shunt amplifier
// assumes a register port with address, write strobe, write data and read data,
// overcurrent detector flags per half-bridge and a pwm input pulse, all synchronous
// read data is registered, so it lags the address by one edge
`timescale 1ns/1ps
// What this block does
// - cycle clear drops retry faults on pwm
// - peak drive time 500 to 4000 ns
// - low-side source current code, reset 111
// - low-side sink current code, reset 111
// - retry wait 4 ms or 50 us
// - dead time 50 to 400 ns
// - mode 00 latches overcurrent fault
// - mode 01 retries automatically, reset value
// - mode 10 reports only, no shutdown
// - mode 11 neither reports nor acts
// - scope bit: all bridges or affected one
// - trip level code, 111 disables monitoring
// - reference divide bit, reset half reference
// - low-side measure point selection
// - amplifier gain 5 to 40, reset 20
// - shunt fault disable suppresses shunt faults
// - calibration bit enables calibration function
// - auto calibration bit starts offset calibration
// - shunt trip level code, reset 11
// - lock 110 blocks writes, 011 unlocks
module gdp_config
  import gdp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [10:0] reg_wdata,
  output logic      [10:0] reg_rdata,
  // lock code riding on each write
  input  wire logic [2:0]  lock_field,
  // fault inputs
  input  wire logic        clear_fault,
  input  wire logic        pwm_input,
  input  wire logic [2:0]  drain_source_overcurrent,
  input  wire logic [2:0]  shunt_overcurrent,
  // fault outputs
  output logic      [2:0]  bridge_shutdown,
  output logic             fault_report,
  // drive and amplifier settings
  output logic      [2:0]  low_side_source_current,
  output logic      [2:0]  low_side_sink_current,
  output logic      [15:0] peak_drive_cycles,
  output logic      [15:0] dead_time_cycles,
  output logic      [2:0]  drain_source_trip_level,
  output logic             drain_source_monitor_en,
  output logic             ref_half,
  output logic             low_side_measure_point,
  output logic      [1:0]  amplifier_gain,
  output logic             shunt_cal_en,
  output logic             auto_cal_start,
  output logic      [1:0]  shunt_trip_level
);
  import gdp_pkg::*;

  // register words, reserved bits kept with the fields
  logic [10:0]   ls_q, ls_d;
  logic [10:0]   oc_q, oc_d;
  logic [10:0]   sa_q, sa_d;
  logic [10:0]   rdata_q, rdata_d;

  // lock and the one-cycle calibration start
  logic          locked_q, locked_d;
  logic          acal_q, acal_d;

  // fault state, bridges hit since the fault began, retry countdown
  gdp_state_t    st_q, st_d;
  logic [2:0]    hit_q, hit_d;
  logic [16:0]   cnt_q, cnt_d;

  // overcurrent flags after the monitor enable and the shunt fault disable
  logic [2:0]    ov;
  gdp_oc_mode_t  mode;
  logic          any_ov;

  function automatic logic [15:0] scale(input int unsigned base, input logic [1:0] code);
    scale = 16'(base << code);
  endfunction

  // field pickers, so every multi-bit field of every register is cut the same way
  function automatic logic [2:0] field3(input logic [10:0] word, input int unsigned lsb);
    field3 = word[lsb +: 3];
  endfunction

  function automatic logic [1:0] field2(input logic [10:0] word, input int unsigned lsb);
    field2 = word[lsb +: 2];
  endfunction

  // an overcurrent flag only counts while its detector is enabled
  function automatic logic [2:0] mask_flags(input logic [2:0] flags, input logic en);
    mask_flags = flags & {3{en}};
  endfunction

  // the lock code travels with every write strobe, whatever the address,
  // so a host can lock or unlock while it writes any register
  function automatic logic lock_request(input logic [2:0] code);
    lock_request = (code == GDP_LOCK_CODE);
  endfunction

  function automatic logic unlock_request(input logic [2:0] code);
    unlock_request = (code == GDP_UNLOCK_CODE);
  endfunction

  // only latching and retrying modes take the bridges out of run;
  // report-only and ignore modes leave the state machine alone
  function automatic logic mode_acts(input gdp_oc_mode_t m);
    mode_acts = (m == GDP_OC_LATCH) || (m == GDP_OC_RETRY);
  endfunction

  // wait loaded when a retrying fault starts; the long wait needs all 17 counter bits
  function automatic logic [16:0] retry_load(input logic short_wait);
    if (short_wait) begin
      retry_load = 17'(GDP_RETRY_SHORT_CYC);
    end else begin
      retry_load = 17'(GDP_RETRY_LONG_CYC);
    end
  endfunction

  // read mux; unmapped addresses read as zero rather than aliasing a register,
  // so a host probing the map sees only the three words
  function automatic logic [10:0] read_word(input logic [3:0]  addr,
                                            input logic [10:0] ls,
                                            input logic [10:0] oc,
                                            input logic [10:0] sa);
    unique case (addr)
      GDP_ADDR_LS: read_word = ls;
      GDP_ADDR_OC: read_word = oc;
      GDP_ADDR_SA: read_word = sa;
      default:     read_word = 11'h000;
    endcase
  endfunction

  // lock, reserved-bit storage and register writes
  // a locking write still lands, because the lock only takes effect on the next edge;
  // an unlocking write is itself still refused, so the host must write again after it
  // reserved bits are stored and read back like any other bit, they only never reach a configuration output
  always_comb begin
    ls_d     = ls_q;
    oc_d     = oc_q;
    sa_d     = sa_q;
    locked_d = locked_q;
    // calibration start is a pulse, dropped again on the edge after the write
    acal_d   = 1'b0;
    if (reg_wr) begin
      if (!locked_q && lock_request(lock_field)) begin
        locked_d = 1'b1;
      end else if (locked_q && unlock_request(lock_field)) begin
        locked_d = 1'b0;
      end
      if (!locked_q) begin
        // the whole word lands, reserved bits included
        unique case (reg_addr)
          GDP_ADDR_LS: ls_d = reg_wdata;
          GDP_ADDR_OC: oc_d = reg_wdata;
          GDP_ADDR_SA: begin
            sa_d   = reg_wdata;
            acal_d = reg_wdata[GDP_ACAL_BIT];
          end
          // unmapped addresses fall through and change nothing
          default: ;
        endcase
      end
    end
  end

  // reset values put every reserved bit at zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ls_q     <= GDP_RST_LS;
      oc_q     <= GDP_RST_OC;
      sa_q     <= GDP_RST_SA;
      locked_q <= 1'b0;
      acal_q   <= 1'b0;
    end else begin
      ls_q     <= ls_d;
      oc_q     <= oc_d;
      sa_q     <= sa_d;
      locked_q <= locked_d;
      acal_q   <= acal_d;
    end
  end

  // read data is registered: it follows the address one edge later, which the
  // host must allow for; the trade buys a clean flop output on the read bus
  always_comb begin
    rdata_d = read_word(reg_addr, ls_q, oc_q, sa_q);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 11'h000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // configuration outputs: every field but the calibration start, the monitor enable and the two cycle counts is a plain slice of its register flops,
  // so a field changes on the edge after the write that carries it;
  // the cycle counts are decoded from flops and only move with a register write

  // low-side source current code; the two lowest codes give the same current
  assign low_side_source_current = field3(ls_q, GDP_SRC_LSB);

  // low-side sink current code; same step pattern as the source side
  assign low_side_sink_current = field3(ls_q, GDP_SNK_LSB);

  // peak drive time in clock cycles, doubling with each code step;
  // the base is rounded up so a slower clock never shortens the drive
  assign peak_drive_cycles = scale(GDP_PEAK_BASE_CYC, field2(ls_q, GDP_TDRV_LSB));

  // dead time in clock cycles; at this clock the shortest step is one cycle,
  // so finer steps would need a faster clock
  assign dead_time_cycles = scale(GDP_DEAD_BASE_CYC, field2(oc_q, GDP_DEAD_LSB));

  // drain-source trip level; the top code turns the monitor off instead
  assign drain_source_trip_level = field3(oc_q, GDP_VDS_LSB);
  assign drain_source_monitor_en = (field3(oc_q, GDP_VDS_LSB) != 3'h7);

  // amplifier reference: high selects half the reference for two-way sensing
  assign ref_half = sa_q[GDP_VDIV_BIT];

  // low-side drain-source measurement to the negative shunt pin when high
  assign low_side_measure_point = sa_q[GDP_LSREF_BIT];

  // amplifier gain code, doubling the gain with each step
  assign amplifier_gain = field2(sa_q, GDP_GAIN_LSB);

  // calibration function enable follows the stored bit level
  assign shunt_cal_en = sa_q[GDP_CAL_BIT];

  // offset calibration start is a pulse, not the stored level, so a second
  // calibration needs a second write
  assign auto_cal_start = acal_q;

  // shunt trip level code
  assign shunt_trip_level = field2(sa_q, GDP_SLVL_LSB);

  // overcurrent handling
  always_comb begin
    mode = gdp_oc_mode_t'(field2(oc_q, GDP_MODE_LSB));
    // a disabled detector is masked here, ahead of every mode, so it neither
    // reports nor shuts down whatever the mode
    ov   = mask_flags(drain_source_overcurrent, drain_source_monitor_en)
         | mask_flags(shunt_overcurrent, ~sa_q[GDP_DSEN_BIT]);
    any_ov = |ov;
  end

  // fault state machine
  // run:   bridges on; a latching or retrying overcurrent leaves run on the next edge
  // fault: latched; the tripped bridges collect further hits until a clear
  // wait:  retry countdown; ends on timeout, on a clear, or with cycle clear on a pwm input
  // the hit set only grows while out of run, so a second bridge tripping during a
  // retry is shut down as well when the scope is per bridge
  // a pwm input outside retry mode does nothing, a latched fault needs a clear
  // the counter is reloaded on every entry to wait, so a stale count never carries over

  always_comb begin
    st_d  = st_q;
    hit_d = hit_q;
    cnt_d = cnt_q;
    unique case (st_q)
      GDP_ST_RUN: begin
        // report-only and ignore modes never leave run
        if (any_ov && mode_acts(mode)) begin
          hit_d = ov;
          if (mode == GDP_OC_LATCH) begin
            st_d = GDP_ST_FAULT;
          end else begin
            st_d = GDP_ST_WAIT;
          end
          cnt_d = retry_load(oc_q[GDP_RETRY_BIT]);
        end
      end
      GDP_ST_FAULT: begin
        hit_d = hit_q | ov;
        // a live overcurrent in the clearing cycle wins over the clear
        if (clear_fault && !any_ov) begin
          st_d  = GDP_ST_RUN;
          hit_d = 3'h0;
        end
      end
      GDP_ST_WAIT: begin
        hit_d = hit_q | ov;
        // the counter holds at zero once run out, so the exit below always fires
        if (cnt_q != 17'h0) begin
          cnt_d = cnt_q - 17'h1;
        end
        // retry ends on timeout, on a clear or, with cycle clear, on a pwm input
        if (cnt_q == 17'h0 || clear_fault ||
            (ls_q[GDP_CBC_BIT] && pwm_input)) begin
          st_d  = GDP_ST_RUN;
          hit_d = 3'h0;
        end
      end
      default: begin
        // an illegal state code falls back to run with no bridges held
        st_d  = GDP_ST_RUN;
        hit_d = 3'h0;
      end
    endcase
  end

  // reset returns to run with no bridges held and no wait pending
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q  <= GDP_ST_RUN;
      hit_q <= 3'h0;
      cnt_q <= 17'h0;
    end else begin
      st_q  <= st_d;
      hit_q <= hit_d;
      cnt_q <= cnt_d;
    end
  end

  // shutdown scope: all bridges or just the tripped ones;
  // per-bridge scope keeps the healthy bridges switching through a retry
  always_comb begin
    if (st_q == GDP_ST_RUN) begin
      bridge_shutdown = 3'h0;
    end else begin
      bridge_shutdown = oc_q[GDP_SCOPE_BIT] ? hit_q : 3'h7;
    end
  end

  // report line: any state out of run, or a live overcurrent in report-only mode;
  // ignore mode and disabled detectors never raise it
  always_comb begin
    fault_report = (st_q != GDP_ST_RUN) ||
                   (any_ov && mode == GDP_OC_REPORT);
  end
endmodule

// ---- test/gdp_config_assertions.sv ----
// port checker for gdp_config, attached by bind
// assumes a lock code takes effect on any write strobe
`timescale 1ns/1ps
module gdp_config_assertions
  import gdp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [10:0] reg_wdata,
  input wire logic [2:0]  lock_field,
  input wire logic [2:0]  low_side_source_current,
  input wire logic [15:0] peak_drive_cycles,
  input wire logic [2:0]  drain_source_trip_level,
  input wire logic        drain_source_monitor_en,
  input wire logic [1:0]  amplifier_gain,
  input wire logic        auto_cal_start,
  input wire logic [2:0]  low_side_sink_current,
  input wire logic [15:0] dead_time_cycles,
  input wire logic        ref_half,
  input wire logic        low_side_measure_point,
  input wire logic        shunt_cal_en,
  input wire logic [1:0]  shunt_trip_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic lk_q, lk_d;
  wire  wr_ok = reg_wr && !lk_q;
  // lock shadow, so the checker knows which writes must land
  always_comb begin
    lk_d = lk_q;
    if (reg_wr) lk_d = lk_q ? lock_field != GDP_UNLOCK_CODE : lock_field == GDP_LOCK_CODE;
  end
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) lk_q <= 1'b0;
    else lk_q <= lk_d;
  sequence sa_wr_s; wr_ok && reg_addr == GDP_ADDR_SA; endsequence
  sequence cal_pulse_s; auto_cal_start ##1 !auto_cal_start; endsequence
  reset_vals_a:
    assert property ($rose(rst_b) |-> low_side_source_current == 3'h7
      && amplifier_gain == 2'h2 && peak_drive_cycles == 16'h50) else $error("bad reset");
  ls_write_a:
    assert property (wr_ok && reg_addr == GDP_ADDR_LS |=> peak_drive_cycles == (16'ha <<
      $past(reg_wdata[9:8])) && low_side_source_current == $past(reg_wdata[6:4]))
      else $error("ls lost");
  oc_write_a:
    assert property (wr_ok && reg_addr == GDP_ADDR_OC |=>
      drain_source_trip_level == $past(reg_wdata[2:0])) else $error("oc lost");
  sa_write_a:
    assert property (sa_wr_s |=> amplifier_gain == $past(reg_wdata[7:6])) else $error("sa lost");
  monitor_en_a:
    assert property (drain_source_monitor_en == (drain_source_trip_level != 3'h7))
      else $error("bad monitor");
  cal_start_a:
    assert property (sa_wr_s ##0 reg_wdata[GDP_ACAL_BIT] |=> cal_pulse_s) else $error("no cal");
  cal_cause_a:
    assert property (auto_cal_start |-> $past(reg_wr) && $past(reg_addr) == GDP_ADDR_SA)
      else $error("stray cal");
  reset_more_a:
    assert property ($rose(rst_b) |-> low_side_sink_current == 3'h7 && dead_time_cycles == 16'h2
      && ref_half && !low_side_measure_point && !shunt_cal_en && shunt_trip_level == 2'h3)
      else $error("bad reset fields");
  ls_sink_a:
    assert property (wr_ok && reg_addr == GDP_ADDR_LS |=>
      low_side_sink_current == $past(reg_wdata[2:0])) else $error("sink lost");
  dead_time_a:
    assert property (wr_ok && reg_addr == GDP_ADDR_OC |=>
      dead_time_cycles == (16'h1 << $past(reg_wdata[9:8]))) else $error("dead lost");
  sa_fields_a:
    assert property (sa_wr_s |=> ref_half == $past(reg_wdata[9])
      && low_side_measure_point == $past(reg_wdata[8]) && shunt_cal_en == $past(reg_wdata[4])
      && shunt_trip_level == $past(reg_wdata[1:0])) else $error("sa fields lost");
  lock_hold_a:
    assert property (reg_wr && lk_q |=> $stable(low_side_source_current)
      && $stable(amplifier_gain) && $stable(drain_source_trip_level)) else $error("lock broken");
endmodule
bind gdp_config gdp_config_assertions i_gdp_config_assertions (.*);

// ---- test/gdp_host_model.sv ----
// host model issuing one-cycle register writes
// assumes the bench raises go one cycle ahead of the write
`timescale 1ns/1ps
module gdp_host_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [3:0]  a,
  input  wire logic [10:0] d,
  input  wire logic [2:0]  l,
  output logic      [3:0]  reg_addr = 4'h0,
  output logic             reg_wr = 1'b0,
  output logic      [10:0] reg_wdata = 11'h0,
  output logic      [2:0]  lock_field = 3'h0
);
  // released data shows the inverse, so a stale word never passes
  always @(posedge clk) begin
    reg_wr <= go;
    reg_addr <= a;
    reg_wdata <= go ? d : ~reg_wdata;
    lock_field <= go ? l : 3'h0;
  end
endmodule

// ---- test/gdp_config_tb_top.sv ----
// self-checking bench for gdp_config driven through the host model
// assumes the checker binds itself
`timescale 1ns/1ps
module gdp_config_tb_top;
  import gdp_pkg::*;
  typedef struct {logic [3:0] a; logic [10:0] d, e;} gdp_rw_t;
  typedef struct {logic [10:0] oc, sa; logic [2:0] ds, sh, sd; logic rp;} gdp_flt_t;
  logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, clear_fault = 1'b0, pwm_input = 1'b0;
  logic [3:0] a = 4'h0, reg_addr;
  logic [10:0] d = 11'h0, reg_wdata, reg_rdata;
  logic [2:0] l = 3'h0, lock_field, bridge_shutdown;
  logic [2:0] drain_source_overcurrent = 3'h0, shunt_overcurrent = 3'h0;
  logic reg_wr, fault_report;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  logic [10:0] rv [3] = '{GDP_RST_LS, GDP_RST_OC, GDP_RST_SA};
  gdp_rw_t rw [8] = '{'{4'h4, 11'h000, 11'h000}, '{4'h4, 11'h7ff, 11'h7ff},
    '{4'h5, 11'h000, 11'h000}, '{4'h5, 11'h7ff, 11'h7ff}, '{4'h6, 11'h7ff, 11'h7ff},
    '{4'h6, 11'h000, 11'h000}, '{4'h7, 11'h7ff, 11'h000}, '{4'h0, 11'h123, 11'h000}};
  gdp_flt_t ft [6] = '{'{11'h000, 11'h000, 3'h2, 3'h0, 3'h7, 1'b1},
    '{11'h020, 11'h000, 3'h0, 3'h4, 3'h4, 1'b1}, '{11'h000, 11'h020, 3'h0, 3'h1, 3'h0, 1'b0},
    '{11'h007, 11'h000, 3'h1, 3'h0, 3'h0, 1'b0}, '{11'h080, 11'h000, 3'h1, 3'h0, 3'h0, 1'b1},
    '{11'h0c0, 11'h000, 3'h1, 3'h0, 3'h0, 1'b0}};
  gdp_config i_gdp_config (.*, .low_side_source_current(), .low_side_sink_current(),
    .peak_drive_cycles(), .dead_time_cycles(), .drain_source_trip_level(), .ref_half(),
    .drain_source_monitor_en(), .low_side_measure_point(), .amplifier_gain(),
    .shunt_cal_en(), .auto_cal_start(), .shunt_trip_level());
  gdp_host_model i_gdp_host_model (.*);
  task automatic chk(string n, logic [10:0] e, logic [10:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // g low turns the write into a plain read of address aa
  task automatic wr(logic [3:0] aa, logic [10:0] dd, logic [2:0] ll = 3'h0, logic g = 1'b1);
    @(posedge clk);
    go <= g;
    a <= aa;
    d <= dd;
    l <= ll;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic hit(logic [2:0] dv, logic [2:0] sv);
    @(posedge clk);
    drain_source_overcurrent <= dv;
    shunt_overcurrent <= sv;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic tick(logic c, logic p);
    @(posedge clk);
    clear_fault <= c;
    pwm_input <= p;
    @(posedge clk);
    clear_fault <= 1'b0;
    pwm_input <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(4'(i + 4), 11'h0, 3'h0, 1'b0);
      chk("reset", rv[i], reg_rdata);
    end
    foreach (rw[i]) begin
      wr(rw[i].a, rw[i].d);
      chk("readback", rw[i].e, reg_rdata);
    end
    foreach (ft[i]) begin
      wr(GDP_ADDR_SA, ft[i].sa);
      wr(GDP_ADDR_OC, ft[i].oc);
      hit(ft[i].ds, ft[i].sh);
      chk("shutdown", 11'(ft[i].sd), 11'(bridge_shutdown));
      chk("report", 11'(ft[i].rp), 11'(fault_report));
      hit(3'h0, 3'h0);
      chk("held", 11'(ft[i].sd), 11'(bridge_shutdown));
      tick(1'b1, 1'b0);
    end
    wr(GDP_ADDR_LS, 11'h000, GDP_LOCK_CODE);
    wr(GDP_ADDR_LS, 11'h7ff);
    chk("locked", 11'h000, reg_rdata);
    wr(GDP_ADDR_LS, 11'h7ff, GDP_UNLOCK_CODE);
    chk("unlock", 11'h000, reg_rdata);
    wr(GDP_ADDR_LS, 11'h7ff);
    chk("open", 11'h7ff, reg_rdata);
    wr(GDP_ADDR_OC, 11'h440);
    hit(3'h1, 3'h0);
    hit(3'h0, 3'h0);
    repeat (985) @(posedge clk);
    #1;
    chk("waiting", 11'h7, 11'(bridge_shutdown));
    repeat (40) @(posedge clk);
    #1;
    chk("retried", 11'h0, 11'(bridge_shutdown));
    hit(3'h1, 3'h0);
    hit(3'h0, 3'h0);
    chk("pwm wait", 11'h7, 11'(bridge_shutdown));
    tick(1'b0, 1'b1);
    chk("pwm clear", 11'h0, 11'(bridge_shutdown));
    print_verdict();
  end
endmodule
